// ===== hw/self_program_flash_control.sv
// self-programming flash control: control/status register, temporary page buffer,
// page erase/write sequencing, lock set and lock/fuse read-back.
// assumes the cpu raises one-cycle store/load strobes with z and r1:r0 on the same clock.
`timescale 1ns/1ps

module self_program_flash_control #(
  parameter int          WORD_BITS   = 6,                 // word-in-page index width
  parameter int          PAGE_BITS   = 8,                 // page index width
  parameter int          NO_CONCURRENT_READ_SECTION_PAGE   = 224,               // first page of no-concurrent-read section
  parameter logic [15:0] BOOT_ADDR   = 16'h3800,          // boot loader reset word
  parameter int          PROG_CYCLES = self_program_flash_pkg::PROG_CYCLES
) (
  input  wire logic                   i_clk_sys,          // system clock
  input  wire logic                   i_rstn,             // async reset, low
  input  wire logic [7:0]             i_addr,             // register address
  input  wire logic [7:0]             i_wdata,            // register write data
  input  wire logic                   i_wr,               // register write strobe
  input  wire logic                   i_rd,               // register read strobe
  output logic      [7:0]             o_rdata,            // read data, cycle after strobe
  input  wire logic                   i_global_irq_en,    // cpu global interrupt flag
  input  wire logic                   i_store,            // store-program strobe
  input  wire logic                   i_load,             // load-program strobe
  input  wire logic [15:0]            i_z,                // z pointer
  input  wire logic [15:0]            i_r1r0,             // r1:r0 data
  input  wire logic                   i_boot_reset_fuse,  // fuse, 0 = programmed
  input  wire logic [7:0]             i_fuse_byte,        // fuse byte for read-back
  output logic      [7:0]             o_load_data,        // lock/fuse read-back byte
  output logic                        o_load_hit,         // read-back replaces flash data
  output logic                        o_store_ready_irq,  // ready interrupt level
  output logic                        o_cpu_halt,         // halt the processor
  output logic                        o_section_blocked,  // rww section not readable
  output logic      [15:0]            o_reset_vector,     // start word after reset
  output logic                        o_flash_erase,      // erase pulse to array
  output logic                        o_flash_write,      // write pulse to array
  output logic      [PAGE_BITS-1:0]   o_flash_page,       // latched page
  output logic      [16*(1<<WORD_BITS)-1:0] o_flash_data, // buffer contents
  output logic      [7:0]             o_lock_bits         // lock bits
);
  localparam int WORDS = 1 << WORD_BITS;

  initial begin
    if (WORD_BITS < 1 || WORD_BITS + PAGE_BITS > 15 || PROG_CYCLES < 1)
      $error("self_program_flash_control: unsupported parameters");
    if (PROG_CYCLES > 65535 || NO_CONCURRENT_READ_SECTION_PAGE < 0 || NO_CONCURRENT_READ_SECTION_PAGE > (1 << PAGE_BITS))
      $error("self_program_flash_control: counter or section bound out of range");
  end

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_PROG  = 4'b0100,
    ST_LOCK  = 4'b1000
  } state_type;

  typedef struct packed {
    state_type               st;
    logic [7:0]              csr;
    logic [2:0]              win;
    logic [15:0]             cnt;
    logic [PAGE_BITS-1:0]    page;
    logic                    erase;
    logic                    no_concurrent_read_section;
    logic                    loading;
    logic [7:0]              lock;
    logic [7:0]              rdata;
    logic [7:0]              ldata;
    logic                    lhit;
    logic                    ers_p;
    logic                    wr_p;
    logic [1:0]              fuse_seen;
    logic [15:0]             vec;
  } ctl_type;

  ctl_type q, d;
  logic [15:0] buf_q [WORDS];
  logic [1:0]  fuse_sync_q;
  logic        buf_clear, buf_store;
  logic [WORD_BITS-1:0] word_idx;
  logic [PAGE_BITS-1:0] page_idx;
  logic [4:0]  cmd;
  logic        csr_wr;

  assign word_idx = i_z[WORD_BITS:1];
  assign page_idx = i_z[WORD_BITS+PAGE_BITS:WORD_BITS+1];
  assign csr_wr   = i_wr && i_addr == self_program_flash_pkg::CSR_ADDR;
  assign cmd      = i_wdata[4:0];

  always_comb begin
    d = q;
    d.ers_p = 1'b0;
    d.wr_p  = 1'b0;
    d.lhit  = 1'b0;
    buf_clear = 1'b0;
    buf_store = 1'b0;
    if (i_rd) begin
      d.rdata = q.csr & 8'hDF;
    end
    if (q.fuse_seen != 2'h3) begin
      d.fuse_seen = q.fuse_seen + 2'h1;
    end
    // the second flop carries the pin only from the second edge after release
    if (q.fuse_seen == 2'h2) begin
      d.vec = fuse_sync_q[1] ? self_program_flash_pkg::APP_RESET_ADDR : BOOT_ADDR;
    end
    if (csr_wr) begin
      d.csr[self_program_flash_pkg::BIT_IRQ_EN] = i_wdata[self_program_flash_pkg::BIT_IRQ_EN];
    end
    unique case (q.st)
      ST_IDLE, ST_ARMED: begin
        if (q.st == ST_ARMED) begin
          d.win = q.win + 3'h1;
          if (i_load && q.csr[4:0] == self_program_flash_pkg::CMD_LOCK_SET
              && q.win < self_program_flash_pkg::LOAD_WINDOW) begin
            d.ldata = i_z[0] ? q.lock : i_fuse_byte;
            d.lhit  = 1'b1;
            d.csr[4:0] = 5'h00;
            d.st = ST_IDLE;
          end else if (i_store) begin
            d.csr[4:0] = 5'h00;
            d.st = ST_IDLE;
            unique case (q.csr[4:0])
              self_program_flash_pkg::CMD_LOAD: begin
                buf_store = 1'b1;
                d.loading = 1'b1;
                d.csr[self_program_flash_pkg::BIT_BUSY] = 1'b0;
              end
              self_program_flash_pkg::CMD_REENABLE: begin
                d.csr[self_program_flash_pkg::BIT_BUSY] = 1'b0;
                buf_clear = 1'b1;
                d.loading = 1'b0;
              end
              self_program_flash_pkg::CMD_LOCK_SET: begin
                d.lock = q.lock & (i_r1r0[7:0] | 8'hC0);
                d.st = ST_LOCK;
                d.cnt = 16'(PROG_CYCLES);
                d.csr[4:0] = q.csr[4:0];
              end
              default: begin                                  // erase or write
                d.page  = page_idx;
                d.erase = q.csr[self_program_flash_pkg::BIT_PAGE_ERASE];
                d.no_concurrent_read_section  = 32'(page_idx) >= NO_CONCURRENT_READ_SECTION_PAGE;
                d.csr[self_program_flash_pkg::BIT_BUSY] =
                  q.csr[self_program_flash_pkg::BIT_BUSY] | (32'(page_idx) < NO_CONCURRENT_READ_SECTION_PAGE);
                d.ers_p = q.csr[self_program_flash_pkg::BIT_PAGE_ERASE];
                d.wr_p  = q.csr[self_program_flash_pkg::BIT_PAGE_WRITE];
                d.cnt = 16'(PROG_CYCLES);
                d.st = ST_PROG;
                d.csr[4:0] = q.csr[4:0];
              end
            endcase
          end else if (q.win == self_program_flash_pkg::STORE_WINDOW - 3'h1) begin
            d.csr[4:0] = 5'h00;
            d.st = ST_IDLE;
          end
        end
        if (csr_wr && (cmd == self_program_flash_pkg::CMD_LOAD
                       || cmd == self_program_flash_pkg::CMD_REENABLE
                       || cmd == self_program_flash_pkg::CMD_LOCK_SET
                       || cmd == self_program_flash_pkg::CMD_PAGE_WRITE
                       || cmd == self_program_flash_pkg::CMD_PAGE_ERASE)) begin
          d.csr[4:0] = cmd;
          d.win = 3'h0;
          d.st = ST_ARMED;
          if (cmd == self_program_flash_pkg::CMD_REENABLE && q.loading) begin
            buf_clear = 1'b1;
            d.loading = 1'b0;
          end
        end
      end
      ST_PROG, ST_LOCK: begin
        d.cnt = q.cnt - 16'h1;
        if (q.cnt == 16'h1) begin
          d.csr[4:0] = 5'h00;
          d.st = ST_IDLE;
          if (q.st == ST_PROG && !q.erase) begin
            buf_clear = 1'b1;
            d.loading = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '{st: ST_IDLE, csr: self_program_flash_pkg::CSR_RESET, lock: self_program_flash_pkg::LOCK_RESET,
             vec: self_program_flash_pkg::APP_RESET_ADDR, default: '0};
      fuse_sync_q <= 2'b11;
    end else begin
      q <= d;
      fuse_sync_q <= {fuse_sync_q[0], i_boot_reset_fuse};
    end
  end

  // buffer clears on reset and clear events; array holds data only, no state
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < WORDS; i++) buf_q[i] <= 16'hFFFF;
    end else if (buf_clear) begin
      for (int i = 0; i < WORDS; i++) buf_q[i] <= 16'hFFFF;
    end else if (buf_store) begin
      buf_q[word_idx] <= i_r1r0;
    end
  end

  always_comb begin
    for (int i = 0; i < WORDS; i++) o_flash_data[16*i +: 16] = buf_q[i];
  end

  // fuses have only an input; no register path writes them
  assign o_reset_vector    = q.vec;
  assign o_rdata           = q.rdata;
  assign o_load_data       = q.ldata;
  assign o_load_hit        = q.lhit;
  assign o_store_ready_irq = q.csr[self_program_flash_pkg::BIT_IRQ_EN] && i_global_irq_en
                             && !q.csr[self_program_flash_pkg::BIT_STORE_EN];
  assign o_cpu_halt        = q.st == ST_PROG && q.no_concurrent_read_section;
  assign o_section_blocked = q.csr[self_program_flash_pkg::BIT_BUSY];
  assign o_flash_erase     = q.ers_p;
  assign o_flash_write     = q.wr_p;
  assign o_flash_page      = q.page;
  assign o_lock_bits       = q.lock;

  a_irq_level: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_store_ready_irq == (q.csr[7] && i_global_irq_en && !q.csr[0]))
    else $error("ready interrupt level wrong");
  a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !o_rdata[5])
    else $error("reserved bit reads one");
  a_window_end: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (q.st == ST_ARMED && q.win == 3'h3 && !i_store && !i_load && !csr_wr) |=> q.csr[0] == 1'b0)
    else $error("store enable outlived window");
  a_prog_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (q.st == ST_PROG && q.cnt > 16'h1) |=> q.csr[0])
    else $error("store enable dropped during programming");
  a_busy_set: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (o_flash_erase || o_flash_write) && 32'(o_flash_page) < NO_CONCURRENT_READ_SECTION_PAGE |-> o_section_blocked)
    else $error("busy not set for section programming");
  a_halt_no_concurrent_read_section: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    $rose(q.st == ST_PROG) && q.no_concurrent_read_section |-> o_cpu_halt)
    else $error("cpu not halted");
  a_page_latch: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (q.st == ST_PROG && $past(q.st) == ST_PROG) |-> $stable(o_flash_page))
    else $error("page moved during operation");
  a_bad_pattern: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (q.st == ST_IDLE && csr_wr && cmd == 5'h07) |=> q.st == ST_IDLE)
    else $error("illegal pattern armed");
  a_load_busy_clr: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    buf_store |=> !o_section_blocked)
    else $error("busy not cleared by load");

  // a store counts only while armed and not overtaken by a fresh csr write
  sequence s_store_taken(logic [4:0] code);
    q.st == ST_ARMED && q.csr[4:0] == code && i_store && !csr_wr;
  endsequence

  sequence s_prog_end;
    q.st == ST_PROG && q.cnt == 16'h1;
  endsequence

  sequence s_lock_read;
    q.st == ST_ARMED && q.csr[4:0] == self_program_flash_pkg::CMD_LOCK_SET && i_load
    && q.win < self_program_flash_pkg::LOAD_WINDOW;
  endsequence

  a_erase_start: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    s_store_taken(self_program_flash_pkg::CMD_PAGE_ERASE) |=> o_flash_erase && o_flash_page == $past(page_idx))
    else $error("erase did not start on its page");
  a_write_start: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    s_store_taken(self_program_flash_pkg::CMD_PAGE_WRITE) |=> o_flash_write && o_flash_page == $past(page_idx))
    else $error("write did not start on its page");
  a_store_no_arm: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (q.st == ST_IDLE && i_store) |=> !o_flash_erase && !o_flash_write)
    else $error("unarmed store started programming");

  // the halt must cover the whole operation, not just its first cycle
  a_halt_start: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    s_store_taken(self_program_flash_pkg::CMD_PAGE_ERASE) ##0 (32'(page_idx) >= NO_CONCURRENT_READ_SECTION_PAGE) |=> o_cpu_halt)
    else $error("cpu not halted at erase start");
  a_halt_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (o_cpu_halt && q.cnt > 16'h1) |=> o_cpu_halt)
    else $error("halt released early");

  a_prog_done: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    s_prog_end |=> !q.csr[0] && q.st == ST_IDLE)
    else $error("store enable stuck after programming");
  a_prog_ignore: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (q.st == ST_PROG && q.cnt > 16'h1 && csr_wr) |=> q.st == ST_PROG && q.csr[4:0] == $past(q.csr[4:0]))
    else $error("command taken during programming");
  a_write_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    s_prog_end ##0 !q.erase |=> o_flash_data == '1)
    else $error("buffer kept after page write");
  a_reenable_clr: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    s_store_taken(self_program_flash_pkg::CMD_REENABLE) |=> !o_section_blocked && o_flash_data == '1)
    else $error("re-enable left busy or buffer");
  a_load_word: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    s_store_taken(self_program_flash_pkg::CMD_LOAD) |=> buf_q[$past(word_idx)] == $past(i_r1r0))
    else $error("buffer word not loaded");

  // lock bits only move towards programmed; only a reset returns them to all ones
  a_lock_only_set: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    s_store_taken(self_program_flash_pkg::CMD_LOCK_SET) |=> (o_lock_bits & ~$past(o_lock_bits)) == 8'h00
    && (o_lock_bits & ~$past(i_r1r0[7:0]) & 8'h3F) == 8'h00)
    else $error("lock bits not set from r0");
  a_lock_done: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (q.st == ST_LOCK && q.cnt == 16'h1) |=> !q.csr[3] && !q.csr[0])
    else $error("lock set bit did not clear");
  a_read_back: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    s_lock_read |=> o_load_hit
    && o_load_data == ($past(i_z[0]) ? $past(o_lock_bits) : $past(i_fuse_byte)))
    else $error("lock or fuse read-back wrong");
  a_window_load: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (q.st == ST_ARMED && q.win >= self_program_flash_pkg::LOAD_WINDOW && i_load && !i_store) |=> !o_load_hit)
    else $error("late load returned read-back");

  a_vector_pick: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (q.fuse_seen == 2'h3) |-> o_reset_vector == (fuse_sync_q[1] ? self_program_flash_pkg::APP_RESET_ADDR : BOOT_ADDR))
    else $error("reset vector does not follow fuse");
endmodule

// ===== common/self_program_flash_pkg.sv
// constants for the self-programming flash control block
// assumes a cpu core that decodes store/load program instructions and hands them over as strobes
package self_program_flash_pkg;
  localparam logic [7:0] CSR_ADDR        = 8'h37;
  localparam logic [7:0] CSR_RESET       = 8'h00;
  localparam int         BIT_IRQ_EN      = 7;
  localparam int         BIT_BUSY        = 6;
  localparam int         BIT_REENABLE    = 4;
  localparam int         BIT_LOCK_SET    = 3;
  localparam int         BIT_PAGE_WRITE  = 2;
  localparam int         BIT_PAGE_ERASE  = 1;
  localparam int         BIT_STORE_EN    = 0;
  localparam logic [4:0] CMD_REENABLE    = 5'h11;
  localparam logic [4:0] CMD_LOCK_SET    = 5'h09;
  localparam logic [4:0] CMD_PAGE_WRITE  = 5'h05;
  localparam logic [4:0] CMD_PAGE_ERASE  = 5'h03;
  localparam logic [4:0] CMD_LOAD        = 5'h01;
  localparam logic [2:0] STORE_WINDOW    = 3'h4;
  localparam logic [2:0] LOAD_WINDOW     = 3'h3;
  localparam logic [7:0] LOCK_RESET      = 8'hFF;
  localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
  localparam int         PROG_TIME_US    = 4;
  localparam int         CLK_MHZ         = 100;
  localparam int         PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
endpackage

// ===== test/cpu_core_model.sv
// cpu core model: issues store/load program strobes with z and r1:r0
// assumes the flash control samples strobes on the rising edge and may halt the core
`timescale 1ns/1ps
module cpu_core_model (
  input  wire logic        i_clk_sys,  // system clock
  input  wire logic        i_halt,     // core halted by flash control
  output logic             o_store,    // store-program strobe
  output logic             o_load,     // load-program strobe
  output logic [15:0]      o_z,        // z pointer
  output logic [15:0]      o_r1r0      // r1:r0 data
);
  initial begin
    o_store = 1'b0;
    o_load  = 1'b0;
    o_z     = 16'h0000;
    o_r1r0  = 16'h0000;
  end

  // a halted core fetches nothing, so the instruction waits while halt stands, for at most 1000 cycles
  task automatic issue(input logic ld, input logic [15:0] z, input logic [15:0] d, output logic ok);
    int n;
    n = 0;
    while (i_halt === 1'b1 && n < 1000) begin
      @(posedge i_clk_sys);
      n++;
    end
    ok = (n < 1000);
    @(posedge i_clk_sys);
    o_store <= ~ld;
    o_load  <= ld;
    o_z     <= z;
    o_r1r0  <= d;
    @(posedge i_clk_sys);
    o_store <= 1'b0;
    o_load  <= 1'b0;
    // registers get reused at once, so the old operands do not linger
    o_z     <= ~z;
    o_r1r0  <= ~d;
  endtask
endmodule

// ===== test/tb_top.sv
// self-checking bench for the self-programming flash control block
// assumes cpu_core_model as the core and a 100 MHz system clock
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module tb_top;
  localparam int PROG = 5;
  logic           i_clk_sys = 1'b0;
  logic           i_rstn = 1'b0;
  logic [7:0]     i_addr = 8'h00;
  logic [7:0]     i_wdata = 8'h00;
  logic           i_wr = 1'b0;
  logic           i_rd = 1'b0;
  logic           i_global_irq_en = 1'b0;
  logic           i_boot_reset_fuse = 1'b1;
  logic [7:0]     i_fuse_byte = 8'h00;
  logic [7:0]     o_rdata, o_load_data, o_lock_bits, o_flash_page, expv;
  logic           o_load_hit, o_store_ready_irq, o_cpu_halt, o_section_blocked, o_flash_erase, o_flash_write;
  logic [15:0]    o_reset_vector, store_z, r1r0, d0, d1;
  logic           store, load, ok;
  logic [1023:0]  o_flash_data;
  logic [31:0]    seed = 32'h000006FC;
  logic [7:0]     exp_q[$];
  logic           rd_seen = 1'b0;
  logic [7:0]     bad_cmd [5] = '{8'h1F, 8'h07, 8'h13, 8'h0B, 8'h02};
  int             miscompares = 0;
  int             compares = 0;

  always #5 i_clk_sys = ~i_clk_sys;

  self_program_flash_control #(.PROG_CYCLES(PROG)) u_dut (.i_clk_sys, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_global_irq_en, .i_store(store), .i_load(load), .i_z(store_z), .i_r1r0(r1r0), .i_boot_reset_fuse,
    .i_fuse_byte, .o_load_data, .o_load_hit, .o_store_ready_irq, .o_cpu_halt, .o_section_blocked, .o_reset_vector,
    .o_flash_erase, .o_flash_write, .o_flash_page, .o_flash_data, .o_lock_bits);
  cpu_core_model u_cpu (.i_clk_sys, .i_halt(o_cpu_halt), .o_store(store), .o_load(load), .o_z(store_z), .o_r1r0(r1r0));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [15:0] zaddr(input logic [7:0] page, input logic [5:0] word);
    return {1'b0, page, word, 1'b0};
  endfunction

  task automatic stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] e);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= 8'h37;
    exp_q.push_back(e);
    @(posedge i_clk_sys);
    i_rd   <= 1'b0;
  endtask

  // arm with a command, then the core issues the instruction inside the window
  task automatic op(input logic [7:0] cmd, input logic ld, input logic [15:0] z, input logic [15:0] d);
    wr(8'h37, cmd);
    u_cpu.issue(ld, z, d, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      stop_test();
    end
  endtask

  always @(posedge i_clk_sys) rd_seen <= i_rd;

  always @(negedge i_clk_sys) begin
    if (rd_seen === 1'b1 || o_load_hit === 1'b1) begin
      expv = exp_q.pop_front();
      if (rd_seen === 1'b1) `CHK(o_rdata, expv)
      else `CHK(o_load_data, expv)
    end
  end

  initial begin
    #500us;
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    #1 `CHK(o_reset_vector, 16'h0000)
    wr(8'h10, 8'h01);
    rd(8'h00);
    wr(8'h37, 8'hA0);
    rd(8'h80);
    i_global_irq_en <= 1'b1;
    foreach (bad_cmd[i]) begin
      wr(8'h37, 8'h80 | bad_cmd[i]);
      rd(8'h80);
    end
    #1 `CHK(o_store_ready_irq, 1'b1)
    wr(8'h37, 8'h81);
    #1 `CHK(o_store_ready_irq, 1'b0)
    wr(8'h37, 8'h00);
    $display("test register finished");
    // erase first, then fill in reverse order, then write the same page
    op(8'h03, 1'b0, zaddr(8'h05, 6'h00), 16'h5A5A);
    #1 `CHK({o_flash_erase, o_section_blocked, o_flash_page}, {2'b11, 8'h05})
    rd(8'h43);
    wr(8'h37, 8'h01);
    repeat (PROG + 3) @(posedge i_clk_sys);
    rd(8'h40);
    seed = xorshift(seed);
    d0 = seed[15:0];
    op(8'h01, 1'b0, zaddr(8'h05, 6'h09) | 16'h0001, d0);
    seed = xorshift(seed);
    d1 = seed[15:0];
    op(8'h01, 1'b0, zaddr(8'h05, 6'h02), d1);
    #1 `CHK({o_flash_data[9*16 +: 16], o_flash_data[2*16 +: 16]}, {d0, d1})
    rd(8'h00);
    op(8'h05, 1'b0, zaddr(8'h05, 6'h00), 16'h1234);
    #1 `CHK({o_flash_write, o_flash_page}, {1'b1, 8'h05})
    repeat (2) @(posedge i_clk_sys);
    `CHK(o_flash_page, 8'h05)
    repeat (PROG + 3) @(posedge i_clk_sys);
    `CHK(o_flash_data[9*16 +: 16], 16'hFFFF)
    op(8'h11, 1'b0, 16'h0000, 16'h0000);
    #1 `CHK(o_section_blocked, 1'b0)
    $display("test page finished");
    op(8'h03, 1'b0, zaddr(8'hE6, 6'h00), 16'h0000);
    #1 `CHK({o_cpu_halt, o_section_blocked}, 2'b10)
    repeat (PROG + 3) @(posedge i_clk_sys);
    op(8'h01, 1'b0, zaddr(8'h00, 6'h03), 16'hC0DE);
    #1 `CHK(o_flash_data[3*16 +: 16], 16'hC0DE)
    wr(8'h37, 8'h01);
    wr(8'h37, 8'h11);
    @(posedge i_clk_sys);
    #1 `CHK(o_flash_data[3*16 +: 16], 16'hFFFF)
    repeat (6) @(posedge i_clk_sys);
    wr(8'h37, 8'h01);
    repeat (6) @(posedge i_clk_sys);
    u_cpu.issue(1'b0, zaddr(8'h00, 6'h04), 16'h0BAD, ok);
    if (ok !== 1'b1) miscompares++;
    #1 `CHK(o_flash_data[4*16 +: 16], 16'hFFFF)
    $display("test window finished");
    op(8'h09, 1'b0, 16'hFFFF, 16'hAAC3);
    repeat (PROG + 3) @(posedge i_clk_sys);
    `CHK(o_lock_bits, 8'hC3)
    exp_q.push_back(8'hC3);
    op(8'h09, 1'b1, 16'h0001, 16'h0000);
    seed = xorshift(seed);
    i_fuse_byte <= seed[7:0];
    exp_q.push_back(seed[7:0]);
    op(8'h09, 1'b1, 16'h0000, 16'h0000);
    repeat (3) @(posedge i_clk_sys);
    $display("test lock finished");
    i_boot_reset_fuse <= 1'b0;
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    #1 `CHK(o_reset_vector, 16'h3800)
    `CHK({o_flash_data[2*16 +: 16], o_lock_bits}, {16'hFFFF, 8'hFF})
    rd(8'h00);
    repeat (2) @(posedge i_clk_sys);
    $display("test reset finished");
    stop_test();
  end
endmodule
